// ===== hw/iodt_defs.svh
// constants for the io delay timer bank: offsets, fields, resets, timing
`ifndef IODT_DEFS_SVH
`define IODT_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IODT_IDX_DLY_BASE 10'h330
`define IODT_IDX_INPUT_GROUP_A_TIMER_SELECT 10'h33A
`define IODT_IDX_INPUT_GROUP_B_TIMER_SELECT 10'h33B
`define IODT_IDX_OUTPUT_GROUP_TIMER_SELECT 10'h33C
`define IODT_IDX_VIRTUAL_OUTPUT_TIMER_SELECT 10'h33D
`define IODT_IDX_AUX_ALARM_MAP 10'h33E
`define IODT_IDX_STATUS 10'h33F

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define IODT_SEL_FIELD_W 4
`define IODT_STAT_IN_LSB 0
`define IODT_STAT_OUT_LSB 8
`define IODT_STAT_VOUT_LSB 12
`define IODT_STAT_STAGE_BIT 16
`define IODT_STAT_PERMIT_BIT 17

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define IODT_DLY_RST 16'h0000
`define IODT_DLY_MAX 16'hEA60
`define IODT_SEL_RST 16'h0000
`define IODT_AUX_RST 8'h00
`define IODT_NUM_TIMERS 5

// ----------------------------------------------------------------------
// timing: one delay unit is a tenth of a second
// ----------------------------------------------------------------------
`define IODT_TICK_MS 100
`define IODT_CLK_MHZ 250
`define IODT_TICK_CYCLES (`IODT_TICK_MS * `IODT_CLK_MHZ * 1000)

`endif

// ===== hw/iodt_pkg.sv
// types shared by the io delay timer bank
package iodt_pkg;

	// a delay value in tenths of a second
	typedef logic [15:0] iodt_dly_t;

	// one timer select field: 0 none, 1 to 5 a timer
	typedef logic [3:0] iodt_sel_t;

	// a whole select register, four fields
	typedef logic [15:0] iodt_selreg_t;

endpackage

// ===== hw/iodt_delay_line.sv
// one delayed signal: on and off delays counted in tenth-second ticks
`timescale 1ns/1ps
`include "iodt_defs.svh"
module iodt_delay_line
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// signal and timing
	input wire logic in_i,
	input wire logic tick_i,
	input wire logic use_i,
	input wire iodt_pkg::iodt_dly_t on_dly_i,
	input wire iodt_pkg::iodt_dly_t off_dly_i,
	// delayed signal
	output logic out_o
);

	logic out_r;
	logic out_nxt;
	iodt_pkg::iodt_dly_t cnt_r;
	iodt_pkg::iodt_dly_t cnt_nxt;
	iodt_pkg::iodt_dly_t dly;

	// next state: the level must differ for more than the delay to flip
	always_comb
	begin
		out_nxt = out_r;
		cnt_nxt = cnt_r;
		dly = out_r ? off_dly_i : on_dly_i;
		if (!use_i)
		begin
			out_nxt = in_i;
			cnt_nxt = `IODT_DLY_RST;
		end
		else if (in_i == out_r)
		begin
			cnt_nxt = `IODT_DLY_RST; // a short pulse restarts the count
		end
		else if (dly == `IODT_DLY_RST)
		begin
			out_nxt = in_i; // zero means no delay
			cnt_nxt = `IODT_DLY_RST;
		end
		else if (tick_i)
		begin
			// first tick may be partial, so flip one tick past the delay
			if (cnt_r >= dly)
			begin
				out_nxt = in_i;
				cnt_nxt = `IODT_DLY_RST;
			end
			else
			begin
				cnt_nxt = 16'(cnt_r + 16'h0001);
			end
		end
	end

	// state registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_r <= 1'b0;
			cnt_r <= `IODT_DLY_RST;
		end
		else
		begin
			out_r <= out_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign out_o = out_r;

endmodule // iodt_delay_line

// ===== hw/iodt_top.sv
// io delay timer bank: five timers delaying inputs and outputs, wishbone slave
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "iodt_defs.svh"
module iodt_top
#(
	parameter int unsigned TICK_CYCLES = `IODT_TICK_CYCLES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// contact pins
	input wire logic [7:0] multi_input_i,
	input wire logic stage_enable_a_i,
	input wire logic stage_enable_b_i,
	input wire logic software_run_permit_i,
	// output requests from drive logic, same clock
	input wire logic [3:0] multi_output_req_i,
	input wire logic [3:0] virtual_logic_output_req_i,
	// delayed and bypassing results
	output logic [7:0] multi_input_filt_o,
	output logic [3:0] multi_output_o,
	output logic [3:0] virtual_logic_output_o,
	output logic power_stage_enable_o,
	output logic alarm_reset_o,
	output logic [7:0] aux_alarm_o,
	output logic software_run_permit_o
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [10:0] pin_meta_r;
	logic [10:0] pin_sync_r;
	logic [7:0] din;
	logic in3_prev_r;

	// two flops before any logic looks at a pin
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_meta_r <= 11'h000;
			pin_sync_r <= 11'h000;
		end
		else
		begin
			pin_meta_r <= {software_run_permit_i, stage_enable_b_i, stage_enable_a_i,
				multi_input_i};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign din = pin_sync_r[7:0];

	// ------------------------------------------------------------------
	// tenth-second tick
	// ------------------------------------------------------------------
	logic [31:0] pre_r;
	logic [31:0] pre_nxt;
	logic tick_r;
	logic tick_nxt;

	// one shared prescaler; all timers step on the same tick
	always_comb
	begin
		tick_nxt = 1'b0;
		pre_nxt = 32'(pre_r + 32'h00000001);
		if (pre_r >= 32'(TICK_CYCLES - 1))
		begin
			pre_nxt = 32'h00000000;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pre_r <= 32'h00000000;
			tick_r <= 1'b0;
		end
		else
		begin
			pre_r <= pre_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	iodt_pkg::iodt_dly_t on_dly_r [`IODT_NUM_TIMERS];
	iodt_pkg::iodt_dly_t on_dly_nxt [`IODT_NUM_TIMERS];
	iodt_pkg::iodt_dly_t off_dly_r [`IODT_NUM_TIMERS];
	iodt_pkg::iodt_dly_t off_dly_nxt [`IODT_NUM_TIMERS];
	iodt_pkg::iodt_selreg_t sel_in_a_r;
	iodt_pkg::iodt_selreg_t sel_in_a_nxt;
	iodt_pkg::iodt_selreg_t sel_in_b_r;
	iodt_pkg::iodt_selreg_t sel_in_b_nxt;
	iodt_pkg::iodt_selreg_t sel_out_r;
	iodt_pkg::iodt_selreg_t sel_out_nxt;
	iodt_pkg::iodt_selreg_t sel_vout_r;
	iodt_pkg::iodt_selreg_t sel_vout_nxt;
	logic [7:0] aux_map_r;
	logic [7:0] aux_map_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;
	logic [31:0] status;
	logic [9:0] idx;
	logic req;

	assign idx = adr_i[11:2];
	assign req = cyc_i && stb_i && !ack_r;

	// byte-lane merge for the sixteen-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [15:0] m;
		m = old;
		if (be[0])
		begin
			m[7:0] = d[7:0];
		end
		if (be[1])
		begin
			m[15:8] = d[15:8];
		end
		return m;
	endfunction

	// delays above the top of range are clipped to it
	function automatic logic [15:0] clip(input logic [15:0] v);
		logic [15:0] c;
		c = (v > `IODT_DLY_MAX) ? `IODT_DLY_MAX : v;
		return c;
	endfunction

	// writes take effect with the ack; unmapped reads return zero
	always_comb
	begin
		on_dly_nxt = on_dly_r;
		off_dly_nxt = off_dly_r;
		sel_in_a_nxt = sel_in_a_r;
		sel_in_b_nxt = sel_in_b_r;
		sel_out_nxt = sel_out_r;
		sel_vout_nxt = sel_vout_r;
		aux_map_nxt = aux_map_r;
		ack_nxt = req;
		dat_nxt = 32'h00000000;
		if (req)
		begin
			for (int k = 0; k < `IODT_NUM_TIMERS; k++)
			begin
				// each timer has its own pair of delay registers
				if (idx == 10'(`IODT_IDX_DLY_BASE + 2 * k))
				begin
					dat_nxt = {16'h0000, on_dly_r[k]};
					if (we_i)
					begin
						on_dly_nxt[k] = clip(merge16(on_dly_r[k], dat_i, sel_i));
					end
				end
				if (idx == 10'(`IODT_IDX_DLY_BASE + 2 * k + 1))
				begin
					dat_nxt = {16'h0000, off_dly_r[k]};
					if (we_i)
					begin
						off_dly_nxt[k] = clip(merge16(off_dly_r[k], dat_i, sel_i));
					end
				end
			end
			// four group select registers, the aux alarm map and status
			unique case (idx)
				`IODT_IDX_INPUT_GROUP_A_TIMER_SELECT:
				begin
					dat_nxt = {16'h0000, sel_in_a_r};
					if (we_i)
					begin
						sel_in_a_nxt = merge16(sel_in_a_r, dat_i, sel_i);
					end
				end
				`IODT_IDX_INPUT_GROUP_B_TIMER_SELECT:
				begin
					dat_nxt = {16'h0000, sel_in_b_r};
					if (we_i)
					begin
						sel_in_b_nxt = merge16(sel_in_b_r, dat_i, sel_i);
					end
				end
				`IODT_IDX_OUTPUT_GROUP_TIMER_SELECT:
				begin
					dat_nxt = {16'h0000, sel_out_r};
					if (we_i)
					begin
						sel_out_nxt = merge16(sel_out_r, dat_i, sel_i);
					end
				end
				`IODT_IDX_VIRTUAL_OUTPUT_TIMER_SELECT:
				begin
					dat_nxt = {16'h0000, sel_vout_r};
					if (we_i)
					begin
						sel_vout_nxt = merge16(sel_vout_r, dat_i, sel_i);
					end
				end
				`IODT_IDX_AUX_ALARM_MAP:
				begin
					dat_nxt = {24'h000000, aux_map_r};
					if (we_i && sel_i[0])
					begin
						aux_map_nxt = dat_i[7:0];
					end
				end
				`IODT_IDX_STATUS:
				begin
					dat_nxt = status; // read only, writes ignored
				end
				default:
				begin
					// delay registers already handled above; others read zero
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int k = 0; k < `IODT_NUM_TIMERS; k++)
			begin
				on_dly_r[k] <= `IODT_DLY_RST;
				off_dly_r[k] <= `IODT_DLY_RST;
			end
			sel_in_a_r <= `IODT_SEL_RST;
			sel_in_b_r <= `IODT_SEL_RST;
			sel_out_r <= `IODT_SEL_RST;
			sel_vout_r <= `IODT_SEL_RST;
			aux_map_r <= `IODT_AUX_RST;
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end
		else
		begin
			on_dly_r <= on_dly_nxt;
			off_dly_r <= off_dly_nxt;
			sel_in_a_r <= sel_in_a_nxt;
			sel_in_b_r <= sel_in_b_nxt;
			sel_out_r <= sel_out_nxt;
			sel_vout_r <= sel_vout_nxt;
			aux_map_r <= aux_map_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// ------------------------------------------------------------------
	// delayed signals: 8 inputs, 4 outputs, 4 virtual outputs
	// ------------------------------------------------------------------
	logic [15:0] line_in;
	logic [15:0] line_out;
	logic [63:0] sel_all;

	// signal j uses field j mod 4 of its group register
	assign line_in = {virtual_logic_output_req_i, multi_output_req_i, din};
	assign sel_all = {sel_vout_r, sel_out_r, sel_in_b_r, sel_in_a_r};

	generate
		for (genvar j = 0; j < 16; j++)
		begin : g_line
			iodt_pkg::iodt_sel_t fsel;
			logic use_t;
			iodt_pkg::iodt_dly_t on_d;
			iodt_pkg::iodt_dly_t off_d;

			// field 1 picks timer one, so 0x0001 in group a delays input one
			assign fsel = sel_all[j * `IODT_SEL_FIELD_W +: `IODT_SEL_FIELD_W];

			// values 6 to 15 act as no timer
			always_comb
			begin
				use_t = 1'b0;
				on_d = `IODT_DLY_RST;
				off_d = `IODT_DLY_RST;
				for (int k = 0; k < `IODT_NUM_TIMERS; k++)
				begin
					if (fsel == 4'(k + 1))
					begin
						use_t = 1'b1;
						on_d = on_dly_r[k];
						off_d = off_dly_r[k];
					end
				end
			end

			// each line keeps its own counter, so one timer serves many
			iodt_delay_line u_line
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.in_i(line_in[j]),
				.tick_i(tick_r),
				.use_i(use_t),
				.on_dly_i(on_d),
				.off_dly_i(off_d),
				.out_o(line_out[j])
			);
		end
	endgenerate

	assign multi_input_filt_o = line_out[7:0];
	assign multi_output_o = line_out[11:8];
	assign virtual_logic_output_o = line_out[15:12];

	// ------------------------------------------------------------------
	// bypass paths
	// ------------------------------------------------------------------
	logic stage_r;
	logic stage_nxt;
	logic permit_r;
	logic permit_nxt;
	logic arst_r;
	logic arst_nxt;
	logic [7:0] aux_r;
	logic [7:0] aux_nxt;

	// safety and alarm paths skip the delay lines entirely
	always_comb
	begin
		stage_nxt = pin_sync_r[8] && pin_sync_r[9];
		permit_nxt = pin_sync_r[10];
		arst_nxt = din[2] && !in3_prev_r;
		aux_nxt = din & aux_map_r;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stage_r <= 1'b0;
			permit_r <= 1'b0;
			arst_r <= 1'b0;
			aux_r <= 8'h00;
			in3_prev_r <= 1'b0;
		end
		else
		begin
			stage_r <= stage_nxt;
			permit_r <= permit_nxt;
			arst_r <= arst_nxt;
			aux_r <= aux_nxt;
			in3_prev_r <= din[2];
		end
	end

	assign power_stage_enable_o = stage_r;
	assign software_run_permit_o = permit_r;
	assign alarm_reset_o = arst_r;
	assign aux_alarm_o = aux_r;

	// status word: delayed levels and the stage and permit bypass levels for software
	always_comb
	begin
		status = 32'h00000000;
		status[`IODT_STAT_IN_LSB +: 8] = line_out[7:0];
		status[`IODT_STAT_OUT_LSB +: 4] = line_out[11:8];
		status[`IODT_STAT_VOUT_LSB +: 4] = line_out[15:12];
		status[`IODT_STAT_STAGE_BIT] = stage_r;
		status[`IODT_STAT_PERMIT_BIT] = permit_r;
	end

endmodule // iodt_top

// ===== sim/iodt_top_asserts.sv
// port checker for the io delay timer bank
`timescale 1ns/1ps
module iodt_top_asserts
#(
	parameter int unsigned TICK_CYCLES = 4
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus handshake
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// pins
	input wire logic [7:0] multi_input_i,
	input wire logic stage_enable_a_i,
	input wire logic stage_enable_b_i,
	input wire logic software_run_permit_i,
	// bypass results
	input wire logic power_stage_enable_o,
	input wire logic alarm_reset_o,
	input wire logic [7:0] aux_alarm_o,
	input wire logic software_run_permit_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----
	// helper: edges since reset, so the pin pipeline no longer holds reset zeros
	// ----
	logic [1:0] warm_r;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			warm_r <= 2'h0;
		end
		else if (warm_r != 2'h3)
		begin
			warm_r <= 2'(warm_r + 2'h1);
		end
	end
	// ----
	// bus answers: exactly one ack, one cycle after the request
	// ----
	a_ack_answers: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_caused: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	// ----
	// bypass paths: three edges of synchroniser and register, never a timer
	// ----
	a_stage_cut_now: assert property (!(stage_enable_a_i && stage_enable_b_i) |-> ##3 !power_stage_enable_o)
		else $error("power stage not cut at once");
	a_stage_passes: assert property ((warm_r == 2'h3 && stage_enable_a_i && stage_enable_b_i) |-> ##3 power_stage_enable_o)
		else $error("power stage enable not passed");
	a_permit_direct: assert property ((warm_r == 2'h3) |-> ##3 (software_run_permit_o == $past(software_run_permit_i, 3)))
		else $error("run permit delayed");
	a_alarm_on_rise: assert property ($rose(multi_input_i[2]) |-> ##3 alarm_reset_o)
		else $error("alarm reset late");
	a_alarm_single: assert property (alarm_reset_o |=> !alarm_reset_o)
		else $error("alarm reset not a pulse");
	a_aux_needs_pin: assert property ((aux_alarm_o != 8'h00) |-> ((aux_alarm_o & ~$past(multi_input_i, 3)) == 8'h00))
		else $error("aux alarm held after pin opened");
endmodule // iodt_top_asserts

bind iodt_top iodt_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) iodt_top_asserts_i (.clk_i, .rst_i, .cyc_i,
	.stb_i, .ack_o, .multi_input_i, .stage_enable_a_i, .stage_enable_b_i, .software_run_permit_i,
	.power_stage_enable_o, .alarm_reset_o, .aux_alarm_o, .software_run_permit_o);

// ===== sim/iodt_contacts.sv
// contact model: switches and relays on the digital input pins
`timescale 1ns/1ps
module iodt_contacts
(
	// clock
	input wire logic clk_i,
	// wanted state: [7:0] inputs, [8] stage a, [9] stage b, [10] permit
	input wire logic [10:0] want_i,
	// contact pins
	output logic [7:0] multi_input_o,
	output logic stage_enable_a_o,
	output logic stage_enable_b_o,
	output logic software_run_permit_o
);
	// enables closed from power-up so the stage and permit pins are not X before the first edge
	initial {software_run_permit_o, stage_enable_b_o, stage_enable_a_o, multi_input_o} = 11'h700;
	// contacts move at an edge; no bounce, no scenario asks for it
	always @(posedge clk_i)
	begin
		{software_run_permit_o, stage_enable_b_o, stage_enable_a_o, multi_input_o} <= want_i;
	end
endmodule // iodt_contacts

// ===== sim/io_delay_timers_bench.sv
// self-checking bench for the io delay timer bank
`timescale 1ns/1ps
`include "iodt_defs.svh"
module io_delay_timers_bench;
	localparam int TK = 4; // short tick keeps delays a few dozen cycles
	localparam int CIDX [5] = '{826, 826, 827, 828, 829};
	localparam int CVAL [5] = '{16'h0001, 16'h0010, 16'h0500, 16'h3000, 16'h0004};
	localparam int CB [5] = '{0, 1, 6, 11, 12};
	localparam int CT [5] = '{1, 1, 5, 3, 4};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [11:0] adr_i = 12'h000;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o, q;
	logic ack_o, stage, alarm, permit, bad;
	logic [10:0] want = 11'h700;
	logic [7:0] multi_input_i, filt, aux;
	logic stage_enable_a_i, stage_enable_b_i, software_run_permit_i;
	logic [3:0] mo_req = 4'h0;
	logic [3:0] vo_req = 4'h0;
	logic [3:0] mo, vo;
	logic [18:0] obs;
	int failures = 0;
	int check_count = 0;
	// every watched output but aux in one word, bit index picks it
	assign obs = {permit, stage, alarm, vo, mo, filt};
	iodt_contacts iodt_contacts_i (.clk_i, .want_i(want), .multi_input_o(multi_input_i),
		.stage_enable_a_o(stage_enable_a_i), .stage_enable_b_o(stage_enable_b_i),
		.software_run_permit_o(software_run_permit_i));
	iodt_top #(.TICK_CYCLES(TK)) iodt_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .multi_input_i, .stage_enable_a_i, .stage_enable_b_i,
		.software_run_permit_i, .multi_output_req_i(mo_req), .virtual_logic_output_req_i(vo_req),
		.multi_input_filt_o(filt), .multi_output_o(mo), .virtual_logic_output_o(vo),
		.power_stage_enable_o(stage), .alarm_reset_o(alarm), .aux_alarm_o(aux),
		.software_run_permit_o(permit));
	// 250 MHz clock
	always #2 clk_i = ~clk_i;
	// ----
	// helpers
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		sel_i <= 4'hF;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			failures++;
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rd(input int idx, input string nm, input logic [31:0] e);
		wb(1'b0, 10'(idx), 32'h0000_0000);
		chk(nm, e, q);
	endtask
	// called just after an edge: pins go through the contact model
	task automatic drv(input int b, input logic v);
		if (b < 8)
			want[b] <= v;
		else if (b < 12)
			mo_req[b - 8] <= v;
		else
			vo_req[b - 12] <= v;
	endtask
	// output must still hold the opposite of v after lo cycles and reach v by hi
	task automatic span(input string nm, input int b, input logic v, input int lo, input int hi);
		int n;
		repeat (lo) @(posedge clk_i);
		chk(nm, 32'(!v), 32'(obs[b]));
		n = lo;
		while (obs[b] !== v && n < hi)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(nm, 32'(v), 32'(obs[b]));
	endtask
	task automatic print_verdict();
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial
	begin
		#(4 * 30000);
		failures++;
		print_verdict();
	end
	// ----
	// scenarios
	// ----
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 15; i++) rd(`IODT_IDX_DLY_BASE + i, "reset value", 32'h0);
		rd(`IODT_IDX_STATUS, "idle status", 32'h0003_0000);
		for (int k = 0; k < 10; k++) wb(1'b1, 10'(`IODT_IDX_DLY_BASE + k), 32'(k / 2 + 1 + k % 2));
		for (int k = 0; k < 10; k++) rd(`IODT_IDX_DLY_BASE + k, "delay", 32'(k / 2 + 1 + k % 2));
		wb(1'b1, 10'(`IODT_IDX_DLY_BASE + 9), 32'h0000_FFFF);
		rd(`IODT_IDX_DLY_BASE + 9, "clipped delay", 32'h0000_EA60);
		wb(1'b1, 10'(`IODT_IDX_DLY_BASE + 9), 32'h0000_0006);
		rd(10'h3FF, "unmapped", 32'h0);
		// each group and field position, on timers 1, 1, 5, 3 and 4
		for (int c = 0; c < 5; c++)
		begin
			wb(1'b1, 10'(CIDX[c]), 32'(CVAL[c]));
			drv(CB[c], 1'b1);
			span("on delay", CB[c], 1'b1, CT[c] * TK, (CT[c] + 1) * TK + 6);
			drv(CB[c], 1'b0);
			span("off delay", CB[c], 1'b0, (CT[c] + 1) * TK, (CT[c] + 2) * TK + 6);
			wb(1'b1, 10'(CIDX[c]), 32'h0);
		end
		drv(5, 1'b1);
		span("no timer", 5, 1'b1, 0, 5);
		drv(5, 1'b0);
		// one timer on two inputs, counted apart
		wb(1'b1, `IODT_IDX_INPUT_GROUP_A_TIMER_SELECT, 32'h0011);
		drv(0, 1'b1);
		span("shared first", 0, 1'b1, TK, 2 * TK + 6);
		drv(1, 1'b1);
		span("shared second", 1, 1'b1, TK, 2 * TK + 6);
		drv(0, 1'b0);
		drv(1, 1'b0);
		// both must be low again, or the next pulse finds input one still on
		span("shared off", 0, 1'b0, 2 * TK, 3 * TK + 6);
		chk("shared off second", 32'h0, 32'(obs[1]));
		// pulse shorter than the on delay is lost
		wb(1'b1, `IODT_IDX_INPUT_GROUP_A_TIMER_SELECT, 32'h0005);
		drv(0, 1'b1);
		repeat (5 * TK - 2) @(posedge clk_i);
		drv(0, 1'b0);
		bad = 1'b0;
		repeat (8 * TK)
		begin
			@(posedge clk_i);
			bad = bad | obs[0];
		end
		chk("short pulse", 32'h0, 32'(bad));
		// bypass paths with long timers attached
		wb(1'b1, `IODT_IDX_INPUT_GROUP_A_TIMER_SELECT, 32'h5500);
		wb(1'b1, `IODT_IDX_AUX_ALARM_MAP, 32'h08);
		drv(2, 1'b1);
		drv(3, 1'b1);
		span("alarm reset", 16, 1'b1, 0, 6);
		@(posedge clk_i);
		chk("aux alarm", 32'h08, 32'(aux));
		chk("delayed copy", 32'h0, 32'(filt[3]));
		drv(2, 1'b0);
		drv(3, 1'b0);
		want[8] <= 1'b0;
		want[10] <= 1'b0;
		span("stage cut", 17, 1'b0, 0, 6);
		chk("permit", 32'h0, 32'(permit));
		want[8] <= 1'b1;
		want[10] <= 1'b1;
		repeat (8) @(posedge clk_i);
		rd(`IODT_IDX_STATUS, "status", 32'h0003_0000);
		print_verdict();
	end
endmodule // io_delay_timers_bench
